// ==== include/tcc_defines.svh ====
// Register offsets, reset values, the one pulse capture value and timing counts of the timer block.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_OFF_CTRL1 8'h00
`define TCC_OFF_CTRL2 8'h04
`define TCC_OFF_STATUS 8'h08
`define TCC_OFF_CAP1_HI 8'h0c
`define TCC_OFF_CAP1_LO 8'h10
`define TCC_OFF_CAP2_HI 8'h14
`define TCC_OFF_CAP2_LO 8'h18
`define TCC_OFF_CMP1_HI 8'h1c
`define TCC_OFF_CMP1_LO 8'h20
`define TCC_OFF_CMP2_HI 8'h24
`define TCC_OFF_CMP2_LO 8'h28
`define TCC_OFF_CNT_HI 8'h2c
`define TCC_OFF_CNT_LO 8'h30
`define TCC_CNT_RESET 16'hfffc
`define TCC_CAP_OPM 16'hfffd
`define TCC_CMP_RESET 16'h8000
`define TCC_EXT_MIN_GAP 3'h4
`endif

// ==== include/tcc_pkg.sv ====
// Types shared by the timer capture and compare block.
package tcc_pkg;
    typedef enum logic [1:0] {
        TCC_CLK_DIV2 = 2'h0,
        TCC_CLK_DIV4 = 2'h1,
        TCC_CLK_DIV8 = 2'h2,
        TCC_CLK_EXT = 2'h3
    } tcc_clk_sel_t;
    // Control register one fields.
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_level_1;
        logic force_level_0;
        logic capture_edge_select_0;
        logic compare_level_1;
        logic compare_level_0;
    } tcc_ctrl1_t;
    // Control register two fields.
    typedef struct packed {
        logic compare_pin_enable_0;
        logic compare_pin_enable_1;
        logic one_pulse_select;
        logic pwm_select;
        tcc_clk_sel_t timer_clock_select;
        logic capture_edge_select_1;
        logic ext_edge_select;
    } tcc_ctrl2_t;
    // Status register fields.
    typedef struct packed {
        logic capture_flag_0;
        logic compare_flag_0;
        logic overflow_flag;
        logic capture_flag_1;
        logic compare_flag_1;
        logic [2:0] unused;
    } tcc_status_t;
endpackage

// ==== logic/tcc_timer.sv ====
// Timer capture, compare and one pulse logic with an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "tcc_defines.svh"
// Notes on behaviour
// - Active capture pin edge copies the 16-bit counter into the capture register.
// - Each capture channel has its own rising or falling edge select bit.
// - Capture sets its flag; interrupt requested when enabled and unmasked, else pending.
// - Capture flag clears after status read seeing it, then capture low access.
// - Reading capture high blocks capture and flag until capture low is read.
// - In one pulse or PWM mode only the second capture channel captures.
// - Capture pins always feed the timer, whatever the pin direction.
// - Each compare register is matched to the counter every timer tick.
// - Compare registers are software read/write, hardware untouched, reset to 8000h.
// - Compare pin output latches are low during reset.
// - Compare flag clears after status read seeing it, then compare low access.
// - Writing compare high stops matches until compare low is written.
// - Without pin enable the pin gets no level, interrupt still possible.
// - Compare flag and pin change while counter equals compare, in normal mode.
// - Force-level copies the level bit to the pin without flag or interrupt.
// - Force-level bits are ignored in one pulse and PWM modes.
// - One pulse select takes over first capture and first compare channels.
// - One pulse trigger loads FFFCh, drives second level, flags, captures FFFDh.
// - One pulse compare match drives the first level bit, ending the pulse.
// - One pulse mode never sets the first compare flag; second still works.
// - With PWM and one pulse both selected, only PWM mode runs.
// - In one pulse mode the second compare only flags time, drives nothing.
// - Counter resets to FFFCh and reloads FFFCh on a counter low write.
// - Timer tick is clock divided by 2, 4 or 8, or the external clock.
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins.
    input wire logic [1:0] capture_pin,
    input wire logic ext_clk_pin,
    output logic [1:0] compare_pin,
    output logic [1:0] compare_pin_oen,
    // Interrupt request and CPU mask.
    input wire logic cpu_irq_mask,
    output logic timer_irq
);
    if (CNT_W != 16) begin : g_cnt_w_check
        $error("tcc_timer supports a 16-bit counter only");
    end

    // ------------------------------------------------------------
    // Registers and signals.
    // ------------------------------------------------------------
    tcc_ctrl1_t ctrl1_r;
    tcc_ctrl2_t ctrl2_r;
    logic [15:0] cnt_r;
    logic [15:0] cap_r [2];
    logic [15:0] cmp_r [2];
    logic [1:0] cap_flag_r;
    logic [1:0] cmp_flag_r;
    logic ovf_flag_r;
    logic [1:0] cap_armed_r;
    logic [1:0] cap_block_r;
    logic [1:0] cmp_block_r;
    logic [1:0] cmp_armed_r;
    logic ovf_armed_r;
    logic [1:0] pin_r;
    logic [7:0] cnt_lo_buf_r;
    logic [1:0] cap_s1_r;
    logic [1:0] cap_s2_r;
    logic [1:0] cap_d_r;
    logic [2:0] ext_s_r;
    logic [2:0] div_r;
    logic [2:0] ext_gap_r;
    logic tick;
    logic pwm_mode;
    logic opm_mode;
    logic [1:0] cap_edge;
    logic [1:0] cmp_match;
    logic opm_trig;
    logic wr_go;
    logic rd_go;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;

    function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    // ------------------------------------------------------------
    // Modes and timer tick.
    // ------------------------------------------------------------
    // PWM wins.
    assign pwm_mode = ctrl2_r.pwm_select;
    assign opm_mode = ctrl2_r.one_pulse_select & ~ctrl2_r.pwm_select;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ext_s_r <= 3'h0;
            ext_gap_r <= 3'h0;
        end else begin
            ext_s_r <= {ext_s_r[1:0], ext_clk_pin};
            if (ext_gap_r != 3'h0) begin
                ext_gap_r <= ext_gap_r - 3'h1;
            end else if (tick) begin
                ext_gap_r <= `TCC_EXT_MIN_GAP - 3'h1;
            end
        end
    end

    always_comb begin
        unique case (ctrl2_r.timer_clock_select)
            TCC_CLK_DIV2: tick = div_r[0];
            TCC_CLK_DIV4: tick = div_r[1:0] == 2'h3;
            TCC_CLK_DIV8: tick = div_r == 3'h7;
            TCC_CLK_EXT: tick = (ext_gap_r == 3'h0) &
                ((ext_s_r[2] ^ ext_s_r[1]) & (ext_s_r[1] == ctrl2_r.ext_edge_select));
        endcase
    end

    // ------------------------------------------------------------
    // Capture edges.
    // ------------------------------------------------------------
    // Two-stage sync.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cap_s1_r <= 2'h0;
            cap_s2_r <= 2'h0;
            cap_d_r <= 2'h0;
        end else begin
            cap_s1_r <= capture_pin;
            cap_s2_r <= cap_s1_r;
            cap_d_r <= cap_s2_r;
        end
    end

    assign cap_edge[0] = (cap_s2_r[0] ^ cap_d_r[0]) &
        (cap_s2_r[0] == ctrl1_r.capture_edge_select_0);
    assign cap_edge[1] = (cap_s2_r[1] ^ cap_d_r[1]) &
        (cap_s2_r[1] == ctrl2_r.capture_edge_select_1);
    assign opm_trig = opm_mode & cap_edge[0];

    assign cmp_match[0] = tick & ~cmp_block_r[0] & (cnt_r == cmp_r[0]);
    assign cmp_match[1] = tick & ~cmp_block_r[1] & (cnt_r == cmp_r[1]);

    // ------------------------------------------------------------
    // Bus write path.
    // ------------------------------------------------------------
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
    assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
    assign wr_go = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & ~s_axi_bvalid;
    assign s_axi_bresp = 2'h0;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_held_r <= 1'b1;
                    aw_addr_r <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_held_r <= 1'b1;
                    w_data_r <= s_axi_wdata;
                end
                if (s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Control registers; only byte lane zero carries data.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl1_r <= '0;
            ctrl2_r <= '0;
        end else if (wr_go & s_axi_wstrb[0]) begin
            if (is_off(wr_addr, `TCC_OFF_CTRL1)) begin
                ctrl1_r <= tcc_ctrl1_t'(wr_data[7:0]);
            end
            if (is_off(wr_addr, `TCC_OFF_CTRL2)) begin
                ctrl2_r <= tcc_ctrl2_t'(wr_data[7:0]);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cmp_r[0] <= `TCC_CMP_RESET;
            cmp_r[1] <= `TCC_CMP_RESET;
            cmp_block_r <= 2'h0;
        end else if (wr_go & s_axi_wstrb[0]) begin
            for (int i = 0; i < 2; i++) begin
                if (is_off(wr_addr, 8'(`TCC_OFF_CMP1_HI + 8 * i))) begin
                    cmp_r[i][15:8] <= wr_data[7:0];
                    cmp_block_r[i] <= 1'b1;
                end
                if (is_off(wr_addr, 8'(`TCC_OFF_CMP1_LO + 8 * i))) begin
                    cmp_r[i][7:0] <= wr_data[7:0];
                    cmp_block_r[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus read path.
    // ------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_go = s_axi_arvalid & s_axi_arready;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr[7:2])
                `TCC_OFF_CTRL1 >> 2: s_axi_rdata <= {24'h0, ctrl1_r};
                `TCC_OFF_CTRL2 >> 2: s_axi_rdata <= {24'h0, ctrl2_r};
                `TCC_OFF_STATUS >> 2: s_axi_rdata <= {24'h0, cap_flag_r[0], cmp_flag_r[0],
                    ovf_flag_r, cap_flag_r[1], cmp_flag_r[1], 3'h0};
                `TCC_OFF_CAP1_HI >> 2: s_axi_rdata <= {24'h0, cap_r[0][15:8]};
                `TCC_OFF_CAP1_LO >> 2: s_axi_rdata <= {24'h0, cap_r[0][7:0]};
                `TCC_OFF_CAP2_HI >> 2: s_axi_rdata <= {24'h0, cap_r[1][15:8]};
                `TCC_OFF_CAP2_LO >> 2: s_axi_rdata <= {24'h0, cap_r[1][7:0]};
                `TCC_OFF_CMP1_HI >> 2: s_axi_rdata <= {24'h0, cmp_r[0][15:8]};
                `TCC_OFF_CMP1_LO >> 2: s_axi_rdata <= {24'h0, cmp_r[0][7:0]};
                `TCC_OFF_CMP2_HI >> 2: s_axi_rdata <= {24'h0, cmp_r[1][15:8]};
                `TCC_OFF_CMP2_LO >> 2: s_axi_rdata <= {24'h0, cmp_r[1][7:0]};
                `TCC_OFF_CNT_HI >> 2: s_axi_rdata <= {24'h0, cnt_r[15:8]};
                `TCC_OFF_CNT_LO >> 2: s_axi_rdata <= {24'h0, cnt_lo_buf_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counter.
    // ------------------------------------------------------------
    // Reset and low-write reload.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_r <= `TCC_CNT_RESET;
            cnt_lo_buf_r <= 8'h00;
        end else begin
            if ((wr_go & s_axi_wstrb[0] & is_off(wr_addr, `TCC_OFF_CNT_LO)) | opm_trig |
                    (pwm_mode & cmp_match[1])) begin
                cnt_r <= `TCC_CNT_RESET;
            end else if (tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            if (rd_go & is_off(s_axi_araddr, `TCC_OFF_CNT_HI)) begin
                cnt_lo_buf_r <= cnt_r[7:0];
            end else if (rd_go & is_off(s_axi_araddr, `TCC_OFF_CNT_LO)) begin
                cnt_lo_buf_r <= cnt_r[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Capture registers and flags.
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cap_r[0] <= 16'h0000;
            cap_r[1] <= 16'h0000;
            cap_flag_r <= 2'h0;
            cap_armed_r <= 2'h0;
            cap_block_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rd_go & is_off(s_axi_araddr, 8'(`TCC_OFF_CAP1_HI + 8 * i))) begin
                    cap_block_r[i] <= 1'b1;
                end else if (rd_go & is_off(s_axi_araddr, 8'(`TCC_OFF_CAP1_LO + 8 * i))) begin
                    cap_block_r[i] <= 1'b0;
                end
                if (rd_go & is_off(s_axi_araddr, `TCC_OFF_STATUS) & cap_flag_r[i]) begin
                    cap_armed_r[i] <= 1'b1;
                end
                if (cap_armed_r[i] & ((rd_go & is_off(s_axi_araddr,
                        8'(`TCC_OFF_CAP1_LO + 8 * i))) | (wr_go &
                        is_off(wr_addr, 8'(`TCC_OFF_CAP1_LO + 8 * i))))) begin
                    cap_flag_r[i] <= 1'b0;
                    cap_armed_r[i] <= 1'b0;
                end
            end
            if (opm_trig) begin
                cap_r[0] <= `TCC_CAP_OPM;
                cap_flag_r[0] <= 1'b1;
            end else if (pwm_mode & cmp_match[1]) begin
                cap_flag_r[0] <= 1'b1;
            // First channel only in normal mode.
            end else if (cap_edge[0] & ~opm_mode & ~pwm_mode & ~cap_block_r[0]) begin
                cap_r[0] <= cnt_r;
                cap_flag_r[0] <= 1'b1;
            end
            if (cap_edge[1] & ~cap_block_r[1]) begin
                cap_r[1] <= cnt_r;
                cap_flag_r[1] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Compare flags and overflow flag.
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cmp_flag_r <= 2'h0;
            cmp_armed_r <= 2'h0;
            ovf_flag_r <= 1'b0;
            ovf_armed_r <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rd_go & is_off(s_axi_araddr, `TCC_OFF_STATUS) & cmp_flag_r[i]) begin
                    cmp_armed_r[i] <= 1'b1;
                end
                if (cmp_armed_r[i] & ((rd_go & is_off(s_axi_araddr,
                        8'(`TCC_OFF_CMP1_LO + 8 * i))) | (wr_go &
                        is_off(wr_addr, 8'(`TCC_OFF_CMP1_LO + 8 * i))))) begin
                    cmp_flag_r[i] <= 1'b0;
                    cmp_armed_r[i] <= 1'b0;
                end
            end
            // No first flag in one pulse.
            if (cmp_match[0] & ~opm_mode & ~pwm_mode) begin
                cmp_flag_r[0] <= 1'b1;
            end
            if (cmp_match[1] & ~pwm_mode) begin
                cmp_flag_r[1] <= 1'b1;
            end
            if (rd_go & is_off(s_axi_araddr, `TCC_OFF_STATUS) & ovf_flag_r) begin
                ovf_armed_r <= 1'b1;
            end
            if (ovf_armed_r & rd_go & is_off(s_axi_araddr, `TCC_OFF_CNT_LO)) begin
                ovf_flag_r <= 1'b0;
                ovf_armed_r <= 1'b0;
            end
            if (tick & (cnt_r == 16'hffff)) begin
                ovf_flag_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Compare pins.
    // ------------------------------------------------------------
    // Latches low in reset.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_r <= 2'h0;
        end else if (pwm_mode) begin
            if (cmp_match[1]) begin
                pin_r[0] <= ctrl1_r.compare_level_1;
            end else if (cmp_match[0]) begin
                pin_r[0] <= ctrl1_r.compare_level_0;
            end
        end else if (opm_mode) begin
            if (opm_trig) begin
                pin_r[0] <= ctrl1_r.compare_level_1;
            end else if (cmp_match[0]) begin
                pin_r[0] <= ctrl1_r.compare_level_0;
            end
        end else begin
            if (cmp_match[0] | ctrl1_r.force_level_0) begin
                pin_r[0] <= ctrl1_r.compare_level_0;
            end
            if (cmp_match[1] | ctrl1_r.force_level_1) begin
                pin_r[1] <= ctrl1_r.compare_level_1;
            end
        end
    end

    assign compare_pin = pin_r;
    assign compare_pin_oen = {~ctrl2_r.compare_pin_enable_1 | opm_mode | pwm_mode,
        ~ctrl2_r.compare_pin_enable_0};

    assign timer_irq = ~cpu_irq_mask & ((ctrl1_r.capture_irq_enable & |cap_flag_r) |
        (ctrl1_r.compare_irq_enable & |cmp_flag_r) |
        (ctrl1_r.overflow_irq_enable & ovf_flag_r));
endmodule

// ==== verification/tcc_timer_monitor.sv ====
// Port checker of the timer capture and compare block.
`timescale 1ns/100ps
module tcc_timer_monitor
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Register bus.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and interrupt.
    input wire logic [1:0] compare_pin,
    input wire logic [1:0] compare_pin_oen,
    input wire logic cpu_irq_mask,
    input wire logic timer_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_pin_reset_low: assert property (
        disable iff (1'b0) !rstn |=> compare_pin == 2'h0 && compare_pin_oen == 2'h3)
        else $error("Compare pins not idle after reset.");
    a_irq_reset_low: assert property (
        disable iff (1'b0) !rstn |=> !timer_irq)
        else $error("Interrupt raised after reset.");
    a_irq_mask_holds: assert property (
        cpu_irq_mask |-> !timer_irq)
        else $error("Interrupt raised while masked.");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("Write response late.");
    a_write_done: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_bresp == 2'h0)
        else $error("Write response not released.");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read response late.");
    a_read_done: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("Read response not released.");
    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("Read taken while response pending.");
endmodule
bind tcc_timer tcc_timer_monitor #(.CNT_W(CNT_W)) mon (.*);

// ==== verification/tcc_pins_model.sv ====
// Model of the capture and external clock pins around the timer.
`timescale 1ns/100ps
module tcc_pins_model (
    // Clock.
    input wire logic clk_sys,
    // Pins.
    output logic [1:0] capture_pin,
    output logic ext_clk_pin
);
    initial begin
        capture_pin = 2'h0;
        ext_clk_pin = 1'b0;
    end
    task automatic pulse(input int ch);
        repeat (2) begin
            @(posedge clk_sys);
            capture_pin[ch] <= ~capture_pin[ch];
            repeat (6) @(posedge clk_sys);
        end
    endtask
    // External clock edges spaced four cycles apart.
    task automatic ext_ticks(input int n);
        repeat (2 * n) begin
            @(posedge clk_sys);
            ext_clk_pin <= ~ext_clk_pin;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule

// ==== verification/timer_capture_compare_one_pulse_test.sv ====
// Register level test of the timer capture and compare block.
`timescale 1ns/100ps
`include "tcc_defines.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module timer_capture_compare_one_pulse_test;
    logic clk_sys, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_clk_pin, cpu_irq_mask, timer_irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, capture_pin, compare_pin, compare_pin_oen;
    int mismatches = 0;
    int samples_checked = 0;
    tcc_timer dut (.*);
    tcc_pins_model pins (.clk_sys(clk_sys), .capture_pin(capture_pin), .ext_clk_pin(ext_clk_pin));
    // ----------------------------------------
    // Bus, pin wait and end of test tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit ta = 0;
        bit tw = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            s_axi_awvalid <= !ta;
            s_axi_wvalid <= !tw;
        end while (!(ta && tw));
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
    endtask
    task automatic wait_pin(input int b, input logic v);
        for (int i = 0; i < 300 && compare_pin[b] !== v; i++) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        cpu_irq_mask = 1'b1;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        `CHK(compare_pin, 2'h0);
        rd(`TCC_OFF_CMP1_HI);
        `CHK(rdat, 32'h80);
        rd(8'h40);
        `CHK(rrsp, 2'h2);
        wr(`TCC_OFF_CTRL1, 8'h02);
        wr(`TCC_OFF_CTRL2, 8'h40);
        wr(`TCC_OFF_CMP2_HI, 8'h00);
        wr(`TCC_OFF_CMP2_LO, 8'h10);
        wr(`TCC_OFF_CNT_LO, 8'h00);
        wait_pin(1, 1'b1);
        `CHK(compare_pin[1], 1'b1);
        `CHK(compare_pin_oen[1], 1'b0);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[3], 1'b1);
        rd(`TCC_OFF_CMP2_LO);
        `CHK(rdat, 32'h10);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[3], 1'b0);
        wr(`TCC_OFF_CTRL1, 8'h84);
        pins.pulse(0);
        `CHK(timer_irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK(timer_irq, 1'b1);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[7], 1'b1);
        rd(`TCC_OFF_CAP1_LO);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[7], 1'b0);
        rd(`TCC_OFF_CAP1_HI);
        pins.pulse(0);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[7], 1'b0);
        rd(`TCC_OFF_CAP1_LO);
        wr(`TCC_OFF_CNT_LO, 8'h00);
        pins.pulse(0);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[7], 1'b1);
        rd(`TCC_OFF_CAP1_HI);
        `CHK(rdat, 32'hff);
        cpu_irq_mask <= 1'b1;
        wr(`TCC_OFF_CMP1_HI, 8'h00);
        wr(`TCC_OFF_CMP1_LO, 8'h20);
        wr(`TCC_OFF_CTRL1, 8'h06);
        wr(`TCC_OFF_CTRL2, 8'ha0);
        pins.pulse(0);
        `CHK(compare_pin[0], 1'b1);
        rd(`TCC_OFF_CAP1_HI);
        `CHK(rdat, 32'hff);
        rd(`TCC_OFF_CAP1_LO);
        `CHK(rdat, 32'hfd);
        wait_pin(0, 1'b0);
        `CHK(compare_pin[0], 1'b0);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[6], 1'b0);
        pins.pulse(1);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[4], 1'b1);
        wr(`TCC_OFF_CTRL1, 8'h0f);
        repeat (2) @(posedge clk_sys);
        `CHK(compare_pin[0], 1'b0);
        wr(`TCC_OFF_CTRL2, 8'h80);
        repeat (2) @(posedge clk_sys);
        `CHK(compare_pin[0], 1'b1);
        rd(`TCC_OFF_STATUS);
        `CHK(rdat[6], 1'b0);
        wr(`TCC_OFF_CTRL2, 8'h0d);
        wr(`TCC_OFF_CNT_LO, 8'h00);
        pins.ext_ticks(4);
        rd(`TCC_OFF_CNT_HI);
        `CHK(rdat, 32'h00);
        end_of_test();
    end
endmodule
